// >>> lrs_ctrl.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "lrs_defines.svh"
module lrs_ctrl (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic chip_reset_pin_in,
   input wire logic por_in,
   input wire logic watchdog_timer_ovf_in,
   input wire logic host_reset_pin_n_in,
   input wire logic host_power_down_pin_n_in,
   input wire logic lpc_clk_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output lrs_pkg::lrs_mode_e mode_out,
   output logic transfer_seq_clr_out,
   output logic irq_seq_clr_out,
   output logic host_flags_clr_out,
   output logic bus_pins_oe_allow_out,
   output logic sideband_oe_allow_out,
   output logic [31:0] opctrl_out,
   output logic [7:0] host_ie_out,
   output logic gate_a20_output_out,
   output logic lpc_pins_port_mode_out
);
   import lrs_pkg::*;

   // ---------------------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------------------
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic pd_prev;
   logic [3:0] pins_raw;
   assign pins_raw = {chip_reset_pin_in, host_reset_pin_n_in, host_power_down_pin_n_in, lpc_clk_in};

   // Every pin passes two flops; only the second stage is read by logic.
   // The stages reset to each pin's idle level (chip reset low, host reset and
   // power-down high, link clock low). No false power-down edge or stray system
   // reset can then follow the release of reset.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sync1 <= 4'h6;
         sync2 <= 4'h6;
         pd_prev <= 1'b1;
      end else begin
         sync1 <= pins_raw;
         sync2 <= sync1;
         pd_prev <= sync2[1];
      end
   end

   logic chip_rst_s;
   logic host_rst_act;
   logic pd_s;
   logic pd_fall;
   logic pd_rise;
   assign chip_rst_s = sync2[3];
   assign host_rst_act = ~sync2[2];
   assign pd_s = sync2[1];
   assign pd_fall = pd_prev & ~pd_s;
   assign pd_rise = ~pd_prev & pd_s;

   // ---------------------------------------------------------------------------
   // Condition sources
   // ---------------------------------------------------------------------------
   logic sys_rst;
   assign sys_rst = chip_rst_s | por_in | watchdog_timer_ovf_in;

   logic soft_reset_bit;
   logic shutdown_arm_bit;
   logic soft_shutdown_bit;
   logic hw_sdn;

   // APB write strobe, taken in the access phase.
   logic wr_en;
   assign wr_en = psel & penable & pwrite;

   // Priority decode: the first active source wins outright.
   function automatic lrs_mode_e pick_mode(input logic s, input logic h, input logic r,
                                           input logic d, input logic q);
      if (s) pick_mode = LRS_MODE_SYS;
      else if (h) pick_mode = LRS_MODE_HRST;
      else if (r) pick_mode = LRS_MODE_SRST;
      else if (d) pick_mode = LRS_MODE_HSDN;
      else if (q) pick_mode = LRS_MODE_SSDN;
      else pick_mode = LRS_MODE_RUN;
   endfunction

   lrs_mode_e next_mode;
   assign next_mode = pick_mode(sys_rst, host_rst_act, soft_reset_bit, hw_sdn, soft_shutdown_bit);

   logic in_lpc_rst;
   logic in_sdn;
   always_comb begin
      in_lpc_rst = 1'b0;
      in_sdn = 1'b0;
      case (next_mode)
         LRS_MODE_HRST, LRS_MODE_SRST: in_lpc_rst = 1'b1;
         LRS_MODE_HSDN, LRS_MODE_SSDN: in_sdn = 1'b1;
         default: ;
      endcase
   end

   // ---------------------------------------------------------------------------
   // Control bits
   // ---------------------------------------------------------------------------
   // Hardware clearing overrides software writes in the same cycle, since the
   // clearing conditions are levels that software cannot argue with.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         soft_reset_bit <= 1'b0;
      end else if (sys_rst || host_rst_act) begin
         soft_reset_bit <= 1'b0;
      end else if (wr_en && paddr == `LRS_ADDR_CTRL) begin
         soft_reset_bit <= pwdata[`LRS_CTRL_SRST];
      end
   end

   // Arm bit: written by firmware, cleared on power-down rising edge.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         shutdown_arm_bit <= 1'b0;
      end else if (sys_rst || host_rst_act || soft_reset_bit) begin
         shutdown_arm_bit <= 1'b0;
      end else if (pd_rise) begin
         shutdown_arm_bit <= 1'b0;
      end else if (wr_en && paddr == `LRS_ADDR_CTRL) begin
         shutdown_arm_bit <= pwdata[`LRS_CTRL_ARM];
      end
   end

   // Hardware shutdown entered on falling edge when armed, left on rising edge.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         hw_sdn <= 1'b0;
      end else if (sys_rst || host_rst_act || soft_reset_bit || pd_rise) begin
         hw_sdn <= 1'b0;
      end else if (pd_fall && shutdown_arm_bit) begin
         hw_sdn <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         soft_shutdown_bit <= 1'b0;
      end else if (sys_rst || host_rst_act || soft_reset_bit || hw_sdn) begin
         soft_shutdown_bit <= 1'b0;
      end else if (wr_en && paddr == `LRS_ADDR_CTRL) begin
         soft_shutdown_bit <= pwdata[`LRS_CTRL_SSDN];
      end
   end

   // ---------------------------------------------------------------------------
   // Retained configuration
   // ---------------------------------------------------------------------------
   // Operation control survives LPC reset and shutdown.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         opctrl_out <= `LRS_OPCTRL_RESET;
      end else if (sys_rst) begin
         opctrl_out <= `LRS_OPCTRL_RESET;
      end else if (wr_en && paddr == `LRS_ADDR_OPCTRL) begin
         opctrl_out <= pwdata;
      end
   end

   // Host interrupt enables survive shutdown only.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         host_ie_out <= `LRS_HOSTIE_RESET;
      end else if (sys_rst || in_lpc_rst) begin
         host_ie_out <= `LRS_HOSTIE_RESET;
      end else if (wr_en && paddr == `LRS_ADDR_HOSTIE) begin
         host_ie_out <= pwdata[7:0];
      end
   end

   // Gate A20 state is kept across shutdown; the command decoder that drives
   // it lives elsewhere, so here it only takes its reset value.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         gate_a20_output_out <= `LRS_GATE_A20_OUTPUT_RESET;
      end else if (sys_rst || in_lpc_rst) begin
         gate_a20_output_out <= `LRS_GATE_A20_OUTPUT_RESET;
      end
   end

   // ---------------------------------------------------------------------------
   // Registered clear and pin-state outputs
   // ---------------------------------------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         mode_out <= LRS_MODE_SYS;
         transfer_seq_clr_out <= 1'b1;
         irq_seq_clr_out <= 1'b1;
         host_flags_clr_out <= 1'b1;
         bus_pins_oe_allow_out <= 1'b0;
         sideband_oe_allow_out <= 1'b0;
         lpc_pins_port_mode_out <= 1'b1;
      end else begin
         mode_out <= next_mode;
         transfer_seq_clr_out <= sys_rst | in_lpc_rst | in_sdn;
         irq_seq_clr_out <= sys_rst | in_lpc_rst | in_sdn;
         host_flags_clr_out <= sys_rst | in_lpc_rst;
         bus_pins_oe_allow_out <= ~(sys_rst | in_lpc_rst | in_sdn);
         sideband_oe_allow_out <= ~(sys_rst | in_sdn);
         lpc_pins_port_mode_out <= sys_rst;
      end
   end

   // ---------------------------------------------------------------------------
   // APB slave: zero wait states, unmapped reads return zero with error.
   // ---------------------------------------------------------------------------
   logic mapped;
   assign mapped = (paddr == `LRS_ADDR_CTRL) || (paddr == `LRS_ADDR_STATUS) ||
                   (paddr == `LRS_ADDR_OPCTRL) || (paddr == `LRS_ADDR_HOSTIE);

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         case (paddr)
            `LRS_ADDR_CTRL: prdata <= {29'h0, soft_shutdown_bit, shutdown_arm_bit, soft_reset_bit};
            `LRS_ADDR_STATUS: prdata <= {24'h0, hw_sdn, pd_s, host_rst_act, next_mode[5:1]};
            `LRS_ADDR_OPCTRL: prdata <= opctrl_out;
            `LRS_ADDR_HOSTIE: prdata <= {24'h0, host_ie_out};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------------
   a_host_rst_clears: assert property (@(posedge clock_in) disable iff (rst_in)
      host_rst_act |=> !soft_reset_bit && !shutdown_arm_bit && !soft_shutdown_bit)
      else $error("host reset did not clear control bits");
   a_srst_holds: assert property (@(posedge clock_in) disable iff (rst_in)
      soft_reset_bit |=> !shutdown_arm_bit && !soft_shutdown_bit)
      else $error("soft reset did not hold bits clear");
   a_hsdn_clears: assert property (@(posedge clock_in) disable iff (rst_in)
      hw_sdn |=> !soft_shutdown_bit)
      else $error("hardware shutdown left soft shutdown set");
   sequence s_armed_fall;
      shutdown_arm_bit && pd_fall && !sys_rst && !host_rst_act && !soft_reset_bit;
   endsequence
   a_sdn_entry: assert property (@(posedge clock_in) disable iff (rst_in)
      s_armed_fall |=> hw_sdn ##1 mode_out == LRS_MODE_HSDN || $past(sys_rst) || $past(host_rst_act))
      else $error("armed shutdown not entered");
   a_rise_disarms: assert property (@(posedge clock_in) disable iff (rst_in)
      pd_rise |=> !shutdown_arm_bit && !hw_sdn)
      else $error("rising power-down did not disarm");
   a_opctrl_kept: assert property (@(posedge clock_in) disable iff (rst_in)
      !sys_rst && !(wr_en && paddr == `LRS_ADDR_OPCTRL) |=> $stable(opctrl_out))
      else $error("operation control changed without system reset");
   a_sys_priority: assert property (@(posedge clock_in) disable iff (rst_in)
      sys_rst |=> mode_out == LRS_MODE_SYS && transfer_seq_clr_out && lpc_pins_port_mode_out)
      else $error("system reset did not win");
   a_sdn_pins: assert property (@(posedge clock_in) disable iff (rst_in)
      in_sdn |=> !bus_pins_oe_allow_out && !sideband_oe_allow_out && !host_flags_clr_out)
      else $error("shutdown pin state wrong");
   a_lrst_pins: assert property (@(posedge clock_in) disable iff (rst_in)
      in_lpc_rst |=> sideband_oe_allow_out && host_flags_clr_out && irq_seq_clr_out)
      else $error("lpc reset pin state wrong");

endmodule // lrs_ctrl

// >>> lrs_defines.svh
`ifndef LRS_DEFINES_SVH
`define LRS_DEFINES_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------------------
`define LRS_ADDR_CTRL 12'h000
`define LRS_ADDR_STATUS 12'h004
`define LRS_ADDR_OPCTRL 12'h008
`define LRS_ADDR_HOSTIE 12'h00c
// ----------------------------------------------------------------------------
// CTRL fields
// ----------------------------------------------------------------------------
`define LRS_CTRL_SRST 0
`define LRS_CTRL_ARM 1
`define LRS_CTRL_SSDN 2
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LRS_OPCTRL_RESET 32'h0000_0000
`define LRS_HOSTIE_RESET 8'h00
`define LRS_GATE_A20_OUTPUT_RESET 1'b1
`endif

// >>> lrs_host_model.sv
`timescale 1ns/1ps
// Host side of the link: drives the active-low reset and power-down pins and the link clock.
module lrs_host_model (
   input wire logic clock_in,
   output logic host_reset_pin_n_out,
   output logic host_power_down_pin_n_out,
   output logic lpc_clk_out
);
   logic clk_run;
   // ----------------------------------------------------------------------
   // Link clock
   // ----------------------------------------------------------------------
   // The link clock stands still while the host is powered down, so the design must not rely on it then.
   initial begin
      clk_run = 1'b1;
      lpc_clk_out = 1'b0;
      host_reset_pin_n_out = 1'b1;
      host_power_down_pin_n_out = 1'b1;
      #7;
      forever #200 lpc_clk_out = clk_run ? ~lpc_clk_out : 1'b0;
   end
   // Pin changes are launched just after a system clock edge.
   task automatic set_rst(input logic v);
      @(posedge clock_in);
      host_reset_pin_n_out <= v;
   endtask
   task automatic set_pd(input logic v);
      @(posedge clock_in);
      clk_run <= v;
      host_power_down_pin_n_out <= v;
   endtask
endmodule // lrs_host_model

// >>> lrs_pkg.sv
package lrs_pkg;
   // Reset/shutdown condition in force, one-hot by priority.
   typedef enum logic [5:0] {
      LRS_MODE_RUN = 6'b000001,
      LRS_MODE_SYS = 6'b000010,
      LRS_MODE_HRST = 6'b000100,
      LRS_MODE_SRST = 6'b001000,
      LRS_MODE_HSDN = 6'b010000,
      LRS_MODE_SSDN = 6'b100000
   } lrs_mode_e;
endpackage

// >>> tb_lpc_slave_reset_shutdown_ctrl.sv
`timescale 1ns/1ps
`include "lrs_defines.svh"
module tb_lpc_slave_reset_shutdown_ctrl;
   import lrs_pkg::*;
   logic clock_in = 1'b0, rst_in = 1'b1, chip = 1'b0, por = 1'b0, wdt = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, m_op;
   logic pready, pslverr, tclr, iclr, hclr, boe, soe, gate_a20_output, pmode, hr_n, pd_n, lclk;
   logic [7:0] hie, m_ie;
   logic [31:0] opc;
   logic err;
   lrs_mode_e mode_out;
   int fail_count = 0, n_tests = 0, seed = 81964;
   always #25 clock_in = ~clock_in;
   lrs_host_model host (.clock_in(clock_in), .host_reset_pin_n_out(hr_n),
      .host_power_down_pin_n_out(pd_n), .lpc_clk_out(lclk));
   lrs_ctrl dut (.clock_in(clock_in), .rst_in(rst_in), .chip_reset_pin_in(chip), .por_in(por),
      .watchdog_timer_ovf_in(wdt), .host_reset_pin_n_in(hr_n), .host_power_down_pin_n_in(pd_n),
      .lpc_clk_in(lclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_out(mode_out), .transfer_seq_clr_out(tclr),
      .irq_seq_clr_out(iclr), .host_flags_clr_out(hclr), .bus_pins_oe_allow_out(boe),
      .sideband_oe_allow_out(soe), .opctrl_out(opc), .host_ie_out(hie), .gate_a20_output_out(gate_a20_output),
      .lpc_pins_port_mode_out(pmode));
   // ----------------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Only one master here, so the request is held until pready and released a full edge before the next.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      // No cycle count is assumed here: only the watchdog ends a hung wait.
      do begin
         @(posedge clock_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_in);
   endtask
   // Expected condition and clear/enable outputs, from the priority order of the conditions.
   task automatic wm(input lrs_mode_e m);
      int k;
      k = 0;
      while (mode_out !== m && k < 40) begin
         @(posedge clock_in);
         k++;
      end
      chk(mode_out, m);
      chk({tclr, iclr}, {2{m != LRS_MODE_RUN}});
      chk(hclr, m inside {LRS_MODE_SYS, LRS_MODE_HRST, LRS_MODE_SRST});
      chk(boe, m == LRS_MODE_RUN);
      chk(soe, m inside {LRS_MODE_RUN, LRS_MODE_HRST, LRS_MODE_SRST});
      chk(pmode, m == LRS_MODE_SYS);
   endtask
   initial begin
      #(3000 * 50);
      fail_count++;
      close_out;
   end
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock_in);
      chk({mode_out, gate_a20_output, pmode}, {LRS_MODE_SYS, 2'b11});
      rst_in <= 1'b0;
      wm(LRS_MODE_RUN);
      chk({opc, hie}, {`LRS_OPCTRL_RESET, `LRS_HOSTIE_RESET});
      apb(1'b0, 12'h010, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      m_op = $random(seed);
      m_ie = $random(seed);
      apb(1'b1, `LRS_ADDR_OPCTRL, m_op);
      apb(1'b1, `LRS_ADDR_HOSTIE, {24'h0, m_ie});
      $display("test config done");
      // Soft reset holds the arm and soft shutdown bits clear.
      apb(1'b1, `LRS_ADDR_CTRL, 32'h7);
      wm(LRS_MODE_SRST);
      apb(1'b0, `LRS_ADDR_CTRL, 32'h0);
      chk(rd, 32'h1);
      chk({opc, hie, gate_a20_output}, {m_op, 8'h00, 1'b1});
      m_ie = $random(seed);
      apb(1'b1, `LRS_ADDR_CTRL, 32'h0);
      apb(1'b1, `LRS_ADDR_HOSTIE, {24'h0, m_ie});
      wm(LRS_MODE_RUN);
      $display("test soft reset done");
      // Armed hardware shutdown, a soft shutdown request inside it, then wake-up.
      apb(1'b1, `LRS_ADDR_CTRL, 32'h2);
      host.set_pd(1'b0);
      wm(LRS_MODE_HSDN);
      apb(1'b1, `LRS_ADDR_CTRL, 32'h6);
      apb(1'b0, `LRS_ADDR_CTRL, 32'h0);
      chk(rd, 32'h2);
      chk({opc, hie}, {m_op, m_ie});
      host.set_pd(1'b1);
      wm(LRS_MODE_RUN);
      apb(1'b0, `LRS_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      $display("test hardware shutdown done");
      // Soft shutdown overridden by the host reset pin.
      apb(1'b1, `LRS_ADDR_CTRL, 32'h4);
      wm(LRS_MODE_SSDN);
      chk(hie, m_ie);
      host.set_rst(1'b0);
      wm(LRS_MODE_HRST);
      apb(1'b1, `LRS_ADDR_CTRL, 32'h1);
      apb(1'b0, `LRS_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk({opc, hie}, {m_op, 8'h00});
      host.set_rst(1'b1);
      wm(LRS_MODE_RUN);
      $display("test host reset done");
      // Each system reset source, one at a time, over a held host reset.
      for (int i = 0; i < 3; i++) begin
         host.set_rst(1'b0);
         chip <= (i == 0);
         por <= (i == 1);
         wdt <= (i == 2);
         wm(LRS_MODE_SYS);
         chk({opc, hie, gate_a20_output}, {32'h0, 8'h00, 1'b1});
         chip <= 1'b0;
         por <= 1'b0;
         wdt <= 1'b0;
         host.set_rst(1'b1);
         wm(LRS_MODE_RUN);
         apb(1'b1, `LRS_ADDR_OPCTRL, m_op);
      end
      $display("test system reset done");
      close_out;
   end
endmodule // tb_lpc_slave_reset_shutdown_ctrl
